// *** core/liu_alarm_defs.vh ***
// register map, field positions and reset values of the alarm and segment block
`ifndef LIU_ALARM_DEFS_VH
`define LIU_ALARM_DEFS_VH

`define LIU_NUM_CH          8
`define LIU_CH_STRIDE       8'h10
`define LIU_OFS_IRQ_EN      4'h4
`define LIU_OFS_LIVE        4'h5
`define LIU_OFS_CHANGE      4'h6
`define LIU_OFS_SEG_ONE     4'h8
`define LIU_OFS_SEG_TWO     4'h9
`define LIU_OFS_SEG_THREE   4'ha
`define LIU_ADDR_GLOBAL     8'h80

`define LIU_BIT_DMO         6
`define LIU_BIT_FLS         5
`define LIU_BIT_LCV         4
`define LIU_BIT_AIS         2
`define LIU_BIT_LOS         1
`define LIU_BIT_QRP         0
`define LIU_BIT_GIE         1
`define LIU_SEG_SIGN        6
`define LIU_USED_MASK       8'h77
`define LIU_SEG_MASK        8'h7f

`define LIU_RST_IRQ_EN      8'h00
`define LIU_RST_CHANGE      8'h00
`define LIU_RST_SEG         7'h00
`define LIU_RST_GIE         1'b0

`endif

// *** core/liu_alarm_status_seg.v ***
// per-channel alarm status, change flags, interrupt gating and pulse segment registers
// Notes on behaviour
// RL1 - live loss bit D1 follows the loss-of-signal input, regardless of enables
// RL2 - loss interrupt needs its channel enable and the global enable both set
// RL3 - live pattern bit D0 follows the pattern-detect input, regardless of enables
// RL4 - pattern interrupt needs its channel enable and the global enable both set
// RL5 - each alarm change sets its latched change flag at D6,D5,D4,D2,D1,D0
// RL6 - reading a channel's change-flag register clears that channel's flags
// RL7 - interrupt asserts for an enabled change when global enable set, else idle
// RL8 - transmitted pulse built from eight segments, four upper and four lower
// RL9 - first segment register gives the overshoot part of the pulse
// RL10 - fifth segment gives the undershoot part of the pulse
// RL11 - segment bit 6 is the sign, 1 positive, 0 negative; six magnitude bits
// RL12 - second and third segments have their own read/write registers, same format
// RL13 - segment bit 7 reads zero; first segment resets to zero
// RL14 - per-channel enable bit masks when 0, allows when 1; resets to 0
// RL15 - global enable at D1 of global control gates all channels; resets to 0
// RL16 - channel n registers sit at channel-0 offset plus n times 0x10
`timescale 1ns/1ps
`default_nettype none
`include "liu_alarm_defs.vh"

module liu_alarm_status_seg (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_b,
    // host register port
    input  wire [7:0]  hostAddr,
    input  wire [7:0]  hostWrData,
    input  wire        hostWr,
    input  wire        hostRd,
    output reg  [7:0]  hostRdData_ff,
    output reg         hostRdValid_ff,
    // alarm levels, one bit per channel
    input  wire [7:0]  driverMonitorAlarm,
    input  wire [7:0]  fifoLimitAlarm,
    input  wire [7:0]  codeViolationAlarm,
    input  wire [7:0]  allOnesAlarm,
    input  wire [7:0]  receiveSignalLoss,
    input  wire [7:0]  testPatternDetect,
    // fifth segment of each channel, seven bits per channel
    input  wire [55:0] fifthSegmentValue,
    // pulse shaper outputs, seven bits per channel
    output wire [55:0] overshootAmp_ff,
    output wire [55:0] undershootAmp_ff,
    output wire [55:0] secondSegmentValue,
    output wire [55:0] thirdSegmentValue,
    // interrupt
    output reg         irqOut_ff
);

    // sign-magnitude segment to two's complement drive level
    function [6:0] seg_to_amp;
        input [6:0] seg;
        begin
            if (seg[`LIU_SEG_SIGN]) begin // [RL11]
                seg_to_amp = {1'b0, seg[5:0]};
            end else begin
                seg_to_amp = 7'h00 - {1'b0, seg[5:0]};
            end
        end
    endfunction

    reg         globalIrqEnable_ff;
    wire [63:0] irqEnableAll;
    wire [63:0] liveAll;
    wire [63:0] changeAll;
    wire [55:0] segOneAll;
    wire [7:0]  chanIrq;

    wire        isChanAddr = ~hostAddr[7];
    wire [2:0]  chanSel    = hostAddr[6:4];
    wire [3:0]  regSel     = hostAddr[3:0];

    genvar g;
    generate
        for (g = 0; g < `LIU_NUM_CH; g = g + 1) begin : gChan
            reg  [7:0] irqEnable_ff;
            reg  [7:0] prevLive_ff;
            reg  [7:0] changeFlags_ff;
            reg  [6:0] segOne_ff;
            reg  [6:0] segTwo_ff;
            reg  [6:0] segThree_ff;
            reg  [6:0] overAmp_ff;
            reg  [6:0] underAmp_ff;
            wire [7:0] live;
            wire [7:0] changeEvt;
            wire [7:0] nxt_changeFlags;
            wire       hit;
            wire       readChange;

            // live bits straight from the alarm inputs, reserved bits zero
            assign live = {1'b0, driverMonitorAlarm[g], fifoLimitAlarm[g],
                           codeViolationAlarm[g], 1'b0, allOnesAlarm[g],
                           receiveSignalLoss[g], testPatternDetect[g]}; // [RL1] [RL3]

            assign hit        = isChanAddr && (chanSel == g); // [RL16]
            assign readChange = hostRd && hit && (regSel == `LIU_OFS_CHANGE);
            // both edges of an alarm count as a change
            assign changeEvt  = (live ^ prevLive_ff) & `LIU_USED_MASK; // [RL5]
            // a change landing on the read cycle survives the clear
            assign nxt_changeFlags = (readChange ? `LIU_RST_CHANGE : changeFlags_ff)
                                     | changeEvt; // [RL6]

            always @(posedge core_clk) begin
                if (!rst_b) begin
                    irqEnable_ff   <= `LIU_RST_IRQ_EN; // [RL14]
                    prevLive_ff    <= 8'h00;
                    changeFlags_ff <= `LIU_RST_CHANGE;
                    segOne_ff      <= `LIU_RST_SEG; // [RL13]
                    segTwo_ff      <= `LIU_RST_SEG;
                    segThree_ff    <= `LIU_RST_SEG;
                end else begin
                    prevLive_ff    <= live;
                    changeFlags_ff <= nxt_changeFlags;
                    if (hostWr && hit) begin
                        if (regSel == `LIU_OFS_IRQ_EN) begin
                            irqEnable_ff <= hostWrData & `LIU_USED_MASK;
                        end else if (regSel == `LIU_OFS_SEG_ONE) begin
                            segOne_ff <= hostWrData[6:0]; // [RL9]
                        end else if (regSel == `LIU_OFS_SEG_TWO) begin
                            segTwo_ff <= hostWrData[6:0]; // [RL12]
                        end else if (regSel == `LIU_OFS_SEG_THREE) begin
                            segThree_ff <= hostWrData[6:0]; // [RL12]
                        end
                    end
                end
            end

            assign irqEnableAll[g*8 +: 8] = irqEnable_ff;
            assign liveAll[g*8 +: 8]      = live;
            assign changeAll[g*8 +: 8]    = changeFlags_ff;
            assign segOneAll[g*7 +: 7]    = segOne_ff;
            assign secondSegmentValue[g*7 +: 7] = segTwo_ff; // [RL8]
            assign thirdSegmentValue[g*7 +: 7]  = segThree_ff; // [RL8]
            // loss and pattern flags gated by their own enables like the rest
            assign chanIrq[g] = |(changeFlags_ff & irqEnable_ff); // [RL2] [RL4] [RL14]

            // one always block per channel keeps each output slice to a single driver
            always @(posedge core_clk) begin
                if (!rst_b) begin
                    overAmp_ff  <= 7'h00;
                    underAmp_ff <= 7'h00;
                end else begin
                    overAmp_ff  <= seg_to_amp(segOne_ff); // [RL9]
                    underAmp_ff <= seg_to_amp(fifthSegmentValue[g*7 +: 7]); // [RL10]
                end
            end

            assign overshootAmp_ff[g*7 +: 7]  = overAmp_ff;
            assign undershootAmp_ff[g*7 +: 7] = underAmp_ff;
        end
    endgenerate

    // global enable, only the interrupt bit of global control lives here
    always @(posedge core_clk) begin
        if (!rst_b) begin
            globalIrqEnable_ff <= `LIU_RST_GIE; // [RL15]
        end else if (hostWr && (hostAddr == `LIU_ADDR_GLOBAL)) begin
            globalIrqEnable_ff <= hostWrData[`LIU_BIT_GIE]; // [RL15]
        end
    end

    // interrupt is a level held while global enable is on and any enabled flag remains set
    always @(posedge core_clk) begin
        if (!rst_b) begin
            irqOut_ff <= 1'b0;
        end else begin
            irqOut_ff <= globalIrqEnable_ff & (|chanIrq); // [RL7] [RL15]
        end
    end

    // read mux; unmapped addresses read zero
    reg [7:0] rdMux;
    always @* begin
        rdMux = 8'h00;
        if (hostAddr == `LIU_ADDR_GLOBAL) begin
            rdMux = {6'h00, globalIrqEnable_ff, 1'b0};
        end else if (isChanAddr && regSel == `LIU_OFS_IRQ_EN) begin
            rdMux = irqEnableAll[chanSel*8 +: 8];
        end else if (isChanAddr && regSel == `LIU_OFS_LIVE) begin
            rdMux = liveAll[chanSel*8 +: 8]; // [RL1] [RL3]
        end else if (isChanAddr && regSel == `LIU_OFS_CHANGE) begin
            rdMux = changeAll[chanSel*8 +: 8];
        end else if (isChanAddr && regSel == `LIU_OFS_SEG_ONE) begin
            rdMux = {1'b0, segOneAll[chanSel*7 +: 7]}; // [RL13]
        end else if (isChanAddr && regSel == `LIU_OFS_SEG_TWO) begin
            rdMux = {1'b0, secondSegmentValue[chanSel*7 +: 7]}; // [RL13]
        end else if (isChanAddr && regSel == `LIU_OFS_SEG_THREE) begin
            rdMux = {1'b0, thirdSegmentValue[chanSel*7 +: 7]}; // [RL13]
        end
    end

    always @(posedge core_clk) begin
        if (!rst_b) begin
            hostRdData_ff  <= 8'h00;
            hostRdValid_ff <= 1'b0;
        end else begin
            hostRdValid_ff <= hostRd;
            if (hostRd) begin
                hostRdData_ff <= rdMux;
            end
        end
    end

endmodule
`default_nettype wire

// *** dv/liu_alarm_status_pulse_segments_tb_top.sv ***
// self-checking bench for the alarm status and pulse segment block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("Error at %0t got %h expected %h", $time, (a), (e)); end end
module liu_alarm_status_pulse_segments_tb_top;
    typedef struct { logic [7:0] a; logic [7:0] d; logic [7:0] q; } liu_row_t;
    logic [7:0]  hostAddr = 8'h00, hostWrData = 8'h00, hostRdData_ff;
    logic        core_clk = 1'b0, rst_b = 1'b0, hostWr = 1'b0, hostRd = 1'b0;
    logic [7:0]  driverMonitorAlarm = 8'h00, fifoLimitAlarm = 8'h00, codeViolationAlarm = 8'h00;
    logic [7:0]  allOnesAlarm = 8'h00, receiveSignalLoss = 8'h00, testPatternDetect = 8'h00;
    logic [55:0] fifthSegmentValue = 56'h0, overshootAmp_ff, undershootAmp_ff;
    logic [55:0] secondSegmentValue, thirdSegmentValue;
    logic        hostRdValid_ff, irqOut_ff;
    int          failures = 0, comparisons = 0, cycles = 0;
    logic [7:0]  rstAddr [4] = '{8'h08, 8'h04, 8'h80, 8'h06};
    liu_row_t    rows [8] = '{'{8'h08, 8'hff, 8'h7f}, '{8'h19, 8'h2a, 8'h2a},
        '{8'h7a, 8'hd5, 8'h55}, '{8'h04, 8'hff, 8'h77}, '{8'h05, 8'hff, 8'h00},
        '{8'h07, 8'hff, 8'h00}, '{8'h90, 8'hff, 8'h00}, '{8'h80, 8'hff, 8'h02}};
    liu_alarm_status_seg i_dut (.core_clk, .rst_b, .hostAddr, .hostWrData, .hostWr, .hostRd,
        .hostRdData_ff, .hostRdValid_ff, .driverMonitorAlarm, .fifoLimitAlarm,
        .codeViolationAlarm, .allOnesAlarm, .receiveSignalLoss, .testPatternDetect,
        .fifthSegmentValue, .overshootAmp_ff, .undershootAmp_ff, .secondSegmentValue,
        .thirdSegmentValue, .irqOut_ff);
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        hostAddr = a;
        hostWrData = d;
        hostWr = 1'b1;
        @(negedge core_clk);
        hostWr = 1'b0;
    endtask
    // a missing valid turns the data unknown so the compare fails
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        hostAddr = a;
        hostRd = 1'b1;
        @(negedge core_clk);
        hostRd = 1'b0;
        `CHK((hostRdValid_ff === 1'b1) ? hostRdData_ff : 8'hxx, e)
    endtask
    initial begin
        repeat (5) @(negedge core_clk);
        rst_b = 1'b1;
        foreach (rstAddr[i]) rc(rstAddr[i], 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rc(rows[i].a, rows[i].q);
        end
        `CHK(overshootAmp_ff[6:0], 7'h3f)
        `CHK(thirdSegmentValue[55:49], 7'h55)
        wr(8'h18, 8'h05);
        fifthSegmentValue = {35'h0, 7'h03, 7'h00, 7'h43};
        @(negedge core_clk);
        `CHK(overshootAmp_ff[13:7], 7'h7b)
        `CHK(undershootAmp_ff[6:0], 7'h03)
        `CHK(undershootAmp_ff[20:14], 7'h7d)
        $display("registers and shaper done");
        receiveSignalLoss = 8'h01;
        rc(8'h05, 8'h02);
        `CHK(irqOut_ff, 1'b1)
        @(negedge core_clk);
        hostAddr = 8'h06;
        hostRd = 1'b1;
        repeat (2) @(negedge core_clk);
        hostRd = 1'b0;
        `CHK(hostRdData_ff, 8'h00)
        `CHK(irqOut_ff, 1'b0)
        {driverMonitorAlarm, fifoLimitAlarm, codeViolationAlarm, allOnesAlarm} = 32'h01010101;
        rc(8'h06, 8'h74);
        wr(8'h04, 8'h00);
        testPatternDetect = 8'h01;
        rc(8'h05, 8'h77);
        `CHK(irqOut_ff, 1'b0)
        rc(8'h06, 8'h01);
        wr(8'h80, 8'h00);
        wr(8'h04, 8'h02);
        receiveSignalLoss = 8'h08;
        repeat (3) @(negedge core_clk);
        `CHK(irqOut_ff, 1'b0)
        wr(8'h80, 8'h02);
        @(negedge core_clk);
        `CHK(irqOut_ff, 1'b1)
        rc(8'h35, 8'h02);
        rc(8'h36, 8'h02);
        $display("alarms and interrupt done");
        rst_b = 1'b0;
        @(negedge core_clk);
        rst_b = 1'b1;
        rc(8'h08, 8'h00);
        $display("second reset done");
        wrap_up();
    end
endmodule
`default_nettype wire

// *** dv/liu_alarm_sva.sv ***
// assertion checker for the alarm status and pulse segment block
`timescale 1ns/1ps
`default_nettype none
module liu_alarm_sva (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // host port
    input wire logic [7:0]  hostAddr,
    input wire logic [7:0]  hostWrData,
    input wire logic        hostWr,
    input wire logic        hostRd,
    input wire logic [7:0]  hostRdData_ff,
    input wire logic        hostRdValid_ff,
    // alarms and shaper
    input wire logic [7:0]  allOnesAlarm,
    input wire logic [7:0]  receiveSignalLoss,
    input wire logic [7:0]  testPatternDetect,
    input wire logic [55:0] fifthSegmentValue,
    input wire logic [55:0] undershootAmp_ff,
    input wire logic [55:0] secondSegmentValue,
    input wire logic        irqOut_ff
);
    logic gieOn_ff;
    logic lossEn_ff;
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            gieOn_ff <= 1'b0;
            lossEn_ff <= 1'b0;
        end else if (hostWr) begin
            if (hostAddr == 8'h80) gieOn_ff <= hostWrData[1];
            if (hostAddr == 8'h04) lossEn_ff <= hostWrData[1];
        end
    end
    function automatic logic [6:0] amp(input logic [6:0] s);
        return s[6] ? {1'b0, s[5:0]} : 7'h00 - {1'b0, s[5:0]};
    endfunction
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    live_status_a: assert property (hostRd && !hostAddr[7] && hostAddr[3:0] == 4'h5 |=>
        hostRdValid_ff && hostRdData_ff[1:0] == $past({receiveSignalLoss[hostAddr[6:4]],
        testPatternDetect[hostAddr[6:4]]})) else $error("live status wrong");
    gie_block_a: assert property (!gieOn_ff |=> !irqOut_ff) else $error("irq without gie");
    loss_irq_a: assert property (gieOn_ff && lossEn_ff && $rose(receiveSignalLoss[0])
        |-> ##2 irqOut_ff) else $error("loss irq missing");
    flag_set_a: assert property ($past(rst_b) && $changed(allOnesAlarm[0]) ##1
        hostRd && hostAddr == 8'h06 |=> hostRdData_ff[2]) else $error("flag not set");
    clear_read_a: assert property ($past(rst_b) && hostRd && hostAddr == 8'h06
        && $stable({allOnesAlarm, receiveSignalLoss, testPatternDetect}) ##1 hostRd
        && hostAddr == 8'h06 |=> hostRdData_ff == 8'h00) else $error("flags not cleared");
    seg_two_a: assert property (hostWr && hostAddr == 8'h19 |=>
        secondSegmentValue[13:7] == $past(hostWrData[6:0])) else $error("segment two");
    under_amp_a: assert property ($past(rst_b) |-> undershootAmp_ff[6:0] ==
        amp($past(fifthSegmentValue[6:0]))) else $error("undershoot wrong");
    seg_msb_a: assert property (hostRd && !hostAddr[7] && hostAddr[3] |=>
        !hostRdData_ff[7]) else $error("segment bit 7 set");
    cover property (irqOut_ff);
    cover property (hostRd && hostAddr == 8'h06);
    cover property (hostWr && hostAddr == 8'h80);
endmodule
bind liu_alarm_status_seg liu_alarm_sva i_sva (.core_clk, .rst_b, .hostAddr, .hostWrData,
    .hostWr, .hostRd, .hostRdData_ff, .hostRdValid_ff, .allOnesAlarm, .receiveSignalLoss,
    .testPatternDetect, .fifthSegmentValue, .undershootAmp_ff, .secondSegmentValue, .irqOut_ff);
`default_nettype wire
